//--- rtl/par_port_pkg.sv
// Shared constants, types and timing counts for the parallel port handshake block
package par_port_pkg;
   // Clock
   localparam int CLK_PERIOD_NS = 50;
   // Input settle filters
   localparam int PERIPH_FLT_NS = 75;
   localparam int PERIPH_FLT_CYC = (PERIPH_FLT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_SETTLE_NS = 50;
   localparam int WAIT_SETTLE_CYC = (WAIT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAULT_FLT_CYC = 1;
   // Forward data setup: three cable round trips
   localparam int CABLE_RT_NS = 25;
   localparam int SETUP_RT_COUNT = 3;
   localparam int SETUP_NS = SETUP_RT_COUNT * CABLE_RT_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Compatible FIFO mode peak rate, one byte per transfer
   localparam int FIFO_RATE_KBPS = 500;
   localparam int FIFO_BYTE_NS = 1000000 / FIFO_RATE_KBPS;
   localparam int FIFO_BYTE_CYC = FIFO_BYTE_NS / CLK_PERIOD_NS;
   // Enhanced-mode cycle time-out
   localparam int EPP_TMO_US = 10;
   localparam int EPP_TMO_CYC = (EPP_TMO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Reset values
   localparam logic [7:0] PD_RST = 8'h00;
   localparam logic FIFO_RST_LVL = 1'b1;

   typedef enum logic [1:0] {
      MODE_FIFO = 2'b00,
      MODE_ECP = 2'b01,
      MODE_EPP = 2'b10
   } port_mode_e;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_F_SETUP = 4'h1,
      ST_F_ACK = 4'h2,
      ST_F_DONE = 4'h3,
      ST_R_WAIT = 4'h4,
      ST_R_ACK = 4'h5,
      ST_E_WAIT = 4'h6,
      ST_E_CMD = 4'h7
   } hs_state_e;

   typedef struct packed {
      logic [7:0] data;
      logic strobe_n;
      logic autofd_n;
      logic nwrite;
   } cable_out_s;
endpackage

//--- rtl/par_port_hs.sv
// Host-side handshake engine of a multi-mode parallel port
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module par_port_hs
   import par_port_pkg::*;
#(
   parameter int TMO_CYC = EPP_TMO_CYC
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Mode control
   input wire port_mode_e i_mode,
   input wire logic i_ecp_reverse,
   input wire logic i_epp_legacy,
   input wire logic i_port_direction_bit,
   // Forward byte stream
   input wire logic i_fwd_valid,
   input wire logic [7:0] i_fwd_data,
   output logic o_fwd_ready,
   // Reverse byte stream
   output logic o_rev_valid,
   output logic [7:0] o_rev_data,
   input wire logic i_rev_ready,
   // Enhanced-mode host cycle
   input wire logic i_epp_req,
   input wire logic i_epp_write,
   input wire logic [7:0] i_epp_wdata,
   output logic o_iochrdy,
   output logic [7:0] o_epp_rdata,
   output logic o_epp_done,
   output logic o_epp_timeout,
   input wire logic i_timeout_clr,
   // Cable
   input wire logic [7:0] i_pd,
   output logic [7:0] o_pd,
   output logic [7:0] o_pd_oe,
   output logic o_strobe_n,
   output logic o_strobe_oe,
   output logic o_autofd_n,
   output logic o_autofd_oe,
   output logic o_nwrite,
   input wire logic i_busy,
   input wire logic i_ack_n,
   input wire logic i_fault_n,
   input wire logic i_wait_n,
   output logic o_periph_request
);

   //////////////////////////////////////////////////////////////////////////
   // Input synchronisers and settle filters: 0 busy, 1 nAck, 2 nWAIT, 3 nFault
   function automatic logic [1:0] flt_lim(input int idx);
      case (idx)
         0, 1: flt_lim = 2'(PERIPH_FLT_CYC);
         2: flt_lim = 2'(WAIT_SETTLE_CYC);
         default: flt_lim = 2'(FAULT_FLT_CYC);
      endcase
   endfunction

   logic [3:0] pin_raw;
   logic [3:0] sync1_q, sync2_q, sync3_q, flt_q;
   logic [1:0] flt_cnt_q [4];
   assign pin_raw = {i_fault_n, i_wait_n, i_ack_n, i_busy};

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_q <= 4'he;
         sync2_q <= 4'he;
         sync3_q <= 4'he;
         flt_q <= 4'he;
         for (int i = 0; i < 4; i++) flt_cnt_q[i] <= 2'h0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int i = 0; i < 4; i++) begin
            // Edge taken only after the second and third stages agree long enough
            if (sync2_q[i] != sync3_q[i] || sync3_q[i] == flt_q[i]) begin
               flt_cnt_q[i] <= 2'h0;
            end else if (flt_cnt_q[i] == flt_lim(i) - 2'h1) begin
               flt_q[i] <= sync3_q[i];
               flt_cnt_q[i] <= 2'h0;
            end else begin
               flt_cnt_q[i] <= flt_cnt_q[i] + 2'h1;
            end
         end
      end
   end

   logic busy_f, ack_n_f, wait_n_f;
   assign busy_f = flt_q[0];
   assign ack_n_f = flt_q[1];
   assign wait_n_f = flt_q[2];
   // Request may arrive at any time in forward phase, so it gets only a one-cycle settle filter
   assign o_periph_request = ~flt_q[3];

   //////////////////////////////////////////////////////////////////////////
   // Cable data input, synchronised as a word
   logic [7:0] sync1_pd_q, sync2_pd_q, sync3_pd_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_pd_q <= PD_RST;
         sync2_pd_q <= PD_RST;
         sync3_pd_q <= PD_RST;
      end else begin
         sync1_pd_q <= i_pd;
         sync2_pd_q <= sync1_pd_q;
         sync3_pd_q <= sync2_pd_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Two-entry reverse buffer
   logic [7:0] rbuf_q [2];
   logic [1:0] rcnt_q;
   logic rrd_q, rwr_q;
   logic rev_push, rev_pop, rev_room;
   assign rev_room = (rcnt_q != 2'd2);
   assign rev_pop = o_rev_valid & i_rev_ready;
   assign o_rev_valid = (rcnt_q != 2'd0);
   assign o_rev_data = rbuf_q[rrd_q];

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rcnt_q <= 2'd0;
         rrd_q <= 1'b0;
         rwr_q <= 1'b0;
         rbuf_q[0] <= PD_RST;
         rbuf_q[1] <= PD_RST;
      end else begin
         if (rev_push) begin
            rbuf_q[rwr_q] <= sync3_pd_q;
            rwr_q <= ~rwr_q;
         end
         if (rev_pop) rrd_q <= ~rrd_q;
         rcnt_q <= rcnt_q + 2'(rev_push) - 2'(rev_pop);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Handshake state machine
   hs_state_e state_q, state_d;
   cable_out_s out_q, out_d;
   logic [1:0] setup_q, setup_d;
   logic [5:0] gap_q, gap_d;
   logic [7:0] tmo_q, tmo_d;
   logic pd_dir_q, pd_dir_d;
   logic tmo_flag_q, tmo_set;
   logic done_q, done_d;
   logic [7:0] rdata_q, rdata_d;
   logic fwd_take, rev_start, epp_start, ecp_rev, fwd_idle_lvl;

   assign ecp_rev = (i_mode == MODE_ECP) & i_ecp_reverse;
   // Next byte waits on Busy and the FIFO byte gap count; nAck never enters this term
   assign fwd_take = (state_q == ST_IDLE) & (i_mode != MODE_EPP) & ~ecp_rev
      & ~busy_f & (gap_q == 6'd0) & i_fwd_valid;
   assign o_fwd_ready = fwd_take;
   assign rev_start = (state_q == ST_IDLE) & ecp_rev;
   assign epp_start = (state_q == ST_IDLE) & (i_mode == MODE_EPP) & i_epp_req;
   assign rev_push = (state_q == ST_R_WAIT) & ~ack_n_f & rev_room;
   assign fwd_idle_lvl = ~ecp_rev;

   always_comb begin
      state_d = state_q;
      out_d = out_q;
      setup_d = setup_q;
      gap_d = (gap_q != 6'd0) ? gap_q - 6'd1 : 6'd0;
      tmo_d = 8'h00;
      pd_dir_d = pd_dir_q;
      done_d = 1'b0;
      rdata_d = rdata_q;
      tmo_set = 1'b0;
      out_d.nwrite = 1'b1;
      case (state_q)
         ST_IDLE: begin
            out_d.strobe_n = 1'b1;
            out_d.autofd_n = fwd_idle_lvl;
            pd_dir_d = ~ecp_rev;
            if (fwd_take) begin
               out_d.data = i_fwd_data;
               setup_d = 2'(SETUP_CYC);
               if (i_mode == MODE_FIFO) gap_d = 6'(FIFO_BYTE_CYC - 1);
               state_d = ST_F_SETUP;
            end else if (rev_start) begin
               state_d = ST_R_WAIT;
            end else if (epp_start) begin
               pd_dir_d = i_epp_write;
               out_d.data = i_epp_wdata;
               out_d.nwrite = i_epp_legacy ? i_port_direction_bit : ~i_epp_write;
               state_d = ST_E_WAIT;
            end
         end
         ST_F_SETUP: begin
            // Data launched first; strobe falls after the setup count
            if (setup_q == 2'd1) begin
               out_d.strobe_n = 1'b0;
               state_d = ST_F_ACK;
            end else begin
               setup_d = setup_q - 2'd1;
            end
         end
         ST_F_ACK: begin
            if (busy_f) begin
               out_d.strobe_n = 1'b1;
               state_d = ST_F_DONE;
            end
         end
         ST_F_DONE: begin
            if (!busy_f) state_d = ST_IDLE;
         end
         ST_R_WAIT: begin
            // A full buffer holds off the acknowledge, so no byte is lost
            if (rev_push) begin
               out_d.autofd_n = 1'b1;
               state_d = ST_R_ACK;
            end else if (!ecp_rev && ack_n_f) begin
               state_d = ST_IDLE;
            end
         end
         ST_R_ACK: begin
            if (ack_n_f) begin
               out_d.autofd_n = 1'b0;
               state_d = ST_IDLE;
            end
         end
         ST_E_WAIT, ST_E_CMD: begin
            out_d.nwrite = out_q.nwrite;
            tmo_d = tmo_q + 8'h01;
            if (tmo_q == 8'(TMO_CYC - 1)) begin
               tmo_set = 1'b1;
               out_d.autofd_n = 1'b1;
               out_d.nwrite = 1'b1;
               pd_dir_d = 1'b1;
               done_d = 1'b1;
               state_d = ST_IDLE;
            end else if (state_q == ST_E_WAIT && !wait_n_f) begin
               out_d.autofd_n = 1'b0;
               tmo_d = 8'h00;
               state_d = ST_E_CMD;
            end else if (state_q == ST_E_CMD && wait_n_f) begin
               out_d.autofd_n = 1'b1;
               out_d.nwrite = 1'b1;
               rdata_d = sync3_pd_q;
               pd_dir_d = 1'b1;
               done_d = 1'b1;
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= ST_IDLE;
         out_q <= '{data: PD_RST, strobe_n: 1'b1, autofd_n: 1'b1, nwrite: 1'b1};
         setup_q <= 2'd0;
         gap_q <= 6'd0;
         tmo_q <= 8'h00;
         pd_dir_q <= 1'b1;
         done_q <= 1'b0;
         rdata_q <= PD_RST;
      end else begin
         state_q <= state_d;
         out_q <= out_d;
         setup_q <= setup_d;
         gap_q <= gap_d;
         tmo_q <= tmo_d;
         pd_dir_q <= pd_dir_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
      end
   end

   // Time-out flag: a new time-out beats a clear in the same cycle
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) tmo_flag_q <= 1'b0;
      else tmo_flag_q <= tmo_set | (tmo_flag_q & ~i_timeout_clr);
   end

   //////////////////////////////////////////////////////////////////////////
   // Driver type, switched only in idle while nStrobe rests high
   logic drv_pp_q;
   logic [7:0] pd_oe_d;
   logic strobe_oe_d, autofd_oe_d;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) drv_pp_q <= 1'b0;
      else if (state_q == ST_IDLE && out_q.strobe_n) drv_pp_q <= (i_mode != MODE_FIFO);
   end

   // Open collector only sinks, so a high needs no enable; no glitch on switch
   assign pd_oe_d = {8{pd_dir_q}} & ({8{drv_pp_q}} | ~out_q.data);
   assign strobe_oe_d = drv_pp_q | ~out_q.strobe_n;
   assign autofd_oe_d = drv_pp_q | ~out_q.autofd_n;

   assign o_pd = out_q.data;
   assign o_pd_oe = pd_oe_d;
   assign o_strobe_n = out_q.strobe_n;
   assign o_strobe_oe = strobe_oe_d;
   assign o_autofd_n = out_q.autofd_n;
   assign o_autofd_oe = autofd_oe_d;
   assign o_nwrite = out_q.nwrite;
   assign o_iochrdy = ~(state_q == ST_E_WAIT || state_q == ST_E_CMD);
   assign o_epp_rdata = rdata_q;
   assign o_epp_done = done_q;
   assign o_epp_timeout = tmo_flag_q;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   a_fifo_busy_only: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_q == ST_F_DONE && !busy_f) |=> state_q == ST_IDLE)
      else $error("byte did not end on Busy low");
   a_fifo_byte_gap: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (fwd_take && i_mode == MODE_FIFO) |=> gap_q == 6'(FIFO_BYTE_CYC - 1))
      else $error("FIFO byte spacing not loaded");
   a_fwd_idle_strobe: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_q == ST_IDLE) |-> o_strobe_n)
      else $error("nStrobe low while idle");
   a_strobe_setup: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $fell(o_strobe_n) |-> $past(state_q, SETUP_CYC) == ST_F_SETUP && $stable(o_pd))
      else $error("data setup before nStrobe too short");
   a_strobe_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_q == ST_F_ACK && busy_f) |=> o_strobe_n ##1 !(state_q == ST_F_ACK))
      else $error("nStrobe not raised after Busy high");
   a_rev_ack_cycle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      rev_push |=> o_autofd_n && o_rev_valid)
      else $error("reverse byte not acknowledged");
   a_rev_idle_fd: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_q == ST_IDLE && $past(state_q) == ST_R_ACK) |-> !o_autofd_n)
      else $error("nAutoFd high in reverse idle");
   a_oc_no_high: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!drv_pp_q && o_strobe_oe) |-> !o_strobe_n)
      else $error("open-collector line driven high");
   a_busy_filter: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $changed(busy_f) |-> $past(sync3_q[0], 1) == busy_f && $past(sync3_q[0], 2) == busy_f)
      else $error("Busy accepted before steady");
   a_ack_filter: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $changed(ack_n_f) |-> $past(sync3_q[1], 1) == ack_n_f && $past(sync3_q[1], 2) == ack_n_f)
      else $error("nAck accepted before steady");
   a_wait_settle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $changed(wait_n_f) |-> $past(sync3_q[2], 1) == wait_n_f)
      else $error("nWAIT accepted before settled");
   a_nwrite_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_q != ST_E_WAIT && state_q != ST_E_CMD) |-> o_nwrite)
      else $error("nWRITE low outside a cycle");
   a_epp_timeout: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (tmo_q == 8'(TMO_CYC - 1) && !o_iochrdy) |=> o_iochrdy && o_epp_timeout && o_epp_done)
      else $error("time-out did not end the cycle");

endmodule

//--- sim/periph_model.sv
// Behavioural cable peripheral for the parallel port handshake bench
`timescale 1ns/1ps
module periph_model (
   // Clock and scenario control
   input wire logic i_clk,
   input wire logic [1:0] i_role,
   input wire logic [3:0] i_lag,
   input wire logic i_mute,
   // Cable lines as resolved on the wire
   input wire logic [7:0] i_pd,
   input wire logic i_strobe_n,
   input wire logic i_autofd_n,
   input wire logic i_nwrite,
   // Peripheral drivers
   output logic o_busy,
   output logic o_ack_n,
   output logic o_wait_n,
   output logic [7:0] o_pd,
   output logic o_pd_oe
);
   logic [7:0] rx_q[$];
   logic [7:0] tx_q[$];
   logic wait_q;
   ////////////////////////////////////////////////////////////
   // Muted peripheral never answers, so the host must time out
   assign o_wait_n = (i_role == 2'h2 && !i_mute) ? wait_q : 1'b1;
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask
   initial begin
      o_busy = 1'b0;
      o_ack_n = 1'b1;
      wait_q = 1'b0;
      o_pd = 8'h00;
      o_pd_oe = 1'b0;
      forever begin
         step(1);
         if (i_role == 2'h0 && i_strobe_n === 1'b0) begin
            rx_q.push_back(i_pd);
            step(i_lag);
            o_busy = 1'b1;
            while (i_strobe_n !== 1'b1) step(1);
            step(i_lag);
            o_busy = 1'b0;
         end else if (i_role == 2'h1 && i_autofd_n === 1'b0 && tx_q.size() > 0) begin
            o_pd = tx_q.pop_front();
            o_pd_oe = 1'b1;
            step(1);
            o_ack_n = 1'b0;
            while (i_autofd_n !== 1'b1) step(1);
            step(i_lag);
            o_ack_n = 1'b1;
            while (i_autofd_n !== 1'b0) step(1);
            // Bus released and held value inverted so stale data cannot pass
            o_pd_oe = 1'b0;
            o_pd = ~o_pd;
         end else if (i_role == 2'h2 && !i_mute && i_autofd_n === 1'b0) begin
            if (i_nwrite === 1'b0) begin
               rx_q.push_back(i_pd);
            end else begin
               o_pd = tx_q.pop_front();
               o_pd_oe = 1'b1;
            end
            step(i_lag);
            wait_q = 1'b1;
            while (i_autofd_n !== 1'b1) step(1);
            o_pd_oe = 1'b0;
            o_pd = ~o_pd;
            step(i_lag);
            wait_q = 1'b0;
         end
      end
   end
endmodule

//--- sim/test_ecp_epp_parallel_handshake.sv
// Self-checking testbench for the parallel port handshake engine
`timescale 1ns/1ps
module test_ecp_epp_parallel_handshake;
   import par_port_pkg::*;
   localparam int TMO = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   port_mode_e mode = MODE_FIFO;
   logic ecp_rev = 0, legacy = 0, dir_bit = 1, fwd_valid = 0, rev_ready = 0, mute = 0;
   logic epp_req = 0, epp_write = 0, tmo_clr = 0, glitch = 0, tb_ack_n = 1, tb_fault_n = 1;
   logic [7:0] fwd_data = 8'h00, epp_wdata = 8'h00;
   logic [1:0] role = 2'h0;
   logic [3:0] lag = 4'h2;
   logic fwd_ready, rev_valid, iochrdy, epp_done, epp_tmo, strobe_n, strobe_oe;
   logic autofd_n, autofd_oe, nwrite, preq, m_busy, m_ack_n, m_wait_n, m_oe;
   logic [7:0] rev_data, epp_rdata, pd, pd_oe, pd_line, m_pd, mon;
   int fails = 0;
   int num_checks = 0;
   ////////////////////////////////////////////////////////////
   // Pull-ups on the cable: an undriven line reads high
   assign pd_line = (pd_oe & pd) | (~pd_oe & (m_oe ? m_pd : 8'hff));
   assign mon = {fwd_ready, rev_valid, iochrdy, epp_done, epp_tmo, strobe_n, autofd_n, preq};
   par_port_hs #(.TMO_CYC(TMO)) par_port_hs_i (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_mode(mode), .i_ecp_reverse(ecp_rev),
      .i_epp_legacy(legacy), .i_port_direction_bit(dir_bit), .i_fwd_valid(fwd_valid),
      .i_fwd_data(fwd_data), .o_fwd_ready(fwd_ready), .o_rev_valid(rev_valid),
      .o_rev_data(rev_data), .i_rev_ready(rev_ready), .i_epp_req(epp_req),
      .i_epp_write(epp_write), .i_epp_wdata(epp_wdata), .o_iochrdy(iochrdy),
      .o_epp_rdata(epp_rdata), .o_epp_done(epp_done), .o_epp_timeout(epp_tmo),
      .i_timeout_clr(tmo_clr), .i_pd(pd_line), .o_pd(pd), .o_pd_oe(pd_oe),
      .o_strobe_n(strobe_n), .o_strobe_oe(strobe_oe), .o_autofd_n(autofd_n),
      .o_autofd_oe(autofd_oe), .o_nwrite(nwrite), .i_busy(m_busy ^ glitch),
      .i_ack_n(m_ack_n & tb_ack_n), .i_fault_n(tb_fault_n), .i_wait_n(m_wait_n),
      .o_periph_request(preq));
   periph_model periph_model_i (
      .i_clk(clk), .i_role(role), .i_lag(lag), .i_mute(mute), .i_pd(pd_line),
      .i_strobe_n(strobe_oe ? strobe_n : 1'b1), .i_autofd_n(autofd_oe ? autofd_n : 1'b1),
      .i_nwrite(nwrite), .o_busy(m_busy), .o_ack_n(m_ack_n), .o_wait_n(m_wait_n),
      .o_pd(m_pd), .o_pd_oe(m_oe));
   ////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Bounded wait on one monitored output
   task automatic await(input int idx, input logic lvl, input int lim, output int n);
      n = 0;
      while (mon[idx] !== lvl && n < lim) begin
         tick(1);
         n++;
      end
      if (mon[idx] !== lvl) check("await", {7'h00, mon[idx]}, {7'h00, lvl});
   endtask
   // Ready follows valid in the same cycle, so it is looked at mid-cycle
   task automatic push_fwd(input logic [7:0] d, input int lim, output int n);
      fwd_data = d;
      fwd_valid = 1'b1;
      n = 0;
      @(negedge clk);
      while (fwd_ready !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      check("fwd_ready", fwd_ready, 1);
      tick(1);
      fwd_valid = 1'b0;
   endtask
   task automatic test_done();
      if (fails == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic t_reset();
      check("strobe_n", strobe_n, 1);
      check("nwrite", nwrite, 1);
      check("iochrdy", iochrdy, 1);
      check("preq", preq, 0);
   endtask
   task automatic t_fifo();
      int n1, n2, n3;
      mode = MODE_FIFO;
      tick(4);
      push_fwd(8'ha5, 20, n1);
      tb_ack_n = 0;
      await(2, 0, 20, n1);
      check("setup", n1, SETUP_CYC);
      check("pd", pd, 8'ha5);
      check("strobe_oe", strobe_oe, 1);
      await(2, 1, 40, n2);
      check("strobe_oe", strobe_oe, 0);
      push_fwd(8'h5a, 80, n3);
      check("gap", (n1 + n2 + n3 + 1) >= FIFO_BYTE_CYC, 1);
      check("gap", (n1 + n2 + n3 + 1) <= FIFO_BYTE_CYC + 1, 1);
      await(2, 0, 20, n1);
      await(2, 1, 40, n2);
      tb_ack_n = 1;
      tick(20);
      check("rx0", periph_model_i.rx_q[0], 8'ha5);
      check("rx1", periph_model_i.rx_q[1], 8'h5a);
   endtask
   task automatic t_ecp_fwd();
      int n;
      mode = MODE_ECP;
      lag = 4'h8;
      tick(4);
      glitch = 1;
      tick(1);
      glitch = 0;
      repeat (6) begin
         tick(1);
         check("busy_f", par_port_hs_i.busy_f, 0);
      end
      push_fwd(8'h3c, 10, n);
      await(2, 0, 10, n);
      check("strobe_oe", strobe_oe, 1);
      check("pd_oe", pd_oe, 8'hff);
      glitch = 1;
      tick(1);
      glitch = 0;
      repeat (4) begin
         tick(1);
         check("strobe_n", strobe_n, 0);
      end
      tb_fault_n = 0;
      await(0, 1, 8, n);
      check("preq", preq, 1);
      tb_fault_n = 1;
      await(0, 0, 8, n);
      await(2, 1, 40, n);
      tick(30);
      check("rx", periph_model_i.rx_q[$], 8'h3c);
   endtask
   task automatic t_ecp_rev();
      int n;
      logic [7:0] exp[3] = '{8'h11, 8'h22, 8'h33};
      role = 2'h1;
      lag = 4'h2;
      ecp_rev = 1;
      tick(6);
      check("autofd_n", autofd_n, 0);
      tb_ack_n = 0;
      tick(1);
      tb_ack_n = 1;
      repeat (4) begin
         tick(1);
         check("autofd_n", autofd_n, 0);
         check("rev_valid", rev_valid, 0);
      end
      foreach (exp[k]) periph_model_i.tx_q.push_back(exp[k]);
      tick(80);
      check("rev_valid", rev_valid, 1);
      check("autofd_n", autofd_n, 0);
      check("tx_left", periph_model_i.tx_q.size(), 0);
      foreach (exp[k]) begin
         await(6, 1, 80, n);
         check("rev_data", rev_data, exp[k]);
         rev_ready = 1;
         tick(1);
         rev_ready = 0;
         tick(1);
      end
      tick(20);
      check("autofd_n", autofd_n, 0);
      ecp_rev = 0;
      tick(10);
   endtask
   task automatic epp_cycle(input logic w, input logic [7:0] d);
      int n;
      epp_write = w;
      epp_wdata = d;
      epp_req = 1;
      tick(1);
      epp_req = 0;
      check("iochrdy", iochrdy, 0);
      await(4, 1, TMO + 60, n);
      check("iochrdy", iochrdy, 1);
      check("nwrite", nwrite, 1);
      tick(10);
   endtask
   task automatic t_epp();
      mode = MODE_EPP;
      tick(6);
      role = 2'h2;
      tick(6);
      epp_cycle(1, 8'h5a);
      check("rx", periph_model_i.rx_q[$], 8'h5a);
      periph_model_i.tx_q.push_back(8'hc3);
      epp_cycle(0, 8'h00);
      check("rdata", epp_rdata, 8'hc3);
      legacy = 1;
      dir_bit = 0;
      epp_cycle(1, 8'h96);
      check("rx", periph_model_i.rx_q[$], 8'h96);
      dir_bit = 1;
      legacy = 0;
      mute = 1;
      // Silent nWAIT must settle high before the cycle starts
      tick(6);
      epp_cycle(1, 8'h00);
      check("timeout", epp_tmo, 1);
      mute = 0;
      tmo_clr = 1;
      tick(1);
      tmo_clr = 0;
      tick(1);
      check("timeout", epp_tmo, 0);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      #(50 * 20000);
      fails++;
      test_done();
   end
   initial begin
      repeat (10) @(posedge clk);
      #2;
      t_reset();
      repeat (6) @(posedge clk);
      #2 rst_n = 1'b1;
      tick(2);
      t_fifo();
      t_ecp_fwd();
      t_ecp_rev();
      t_epp();
      test_done();
   end
endmodule
